// file: src/pdl_ctrl.v
// Host controller that drives a programmable delay line through its pins
// How it works
// R1 - Delay is inherent plus step times code
// R2 - Step size fixed per variant, 0.5-10ns
// R3 - Delay never falls as code rises
// R4 - Device gives true and inverted outputs
// R5 - Disable high forces outputs low and high
// R6 - Both disable pins always driven alike
// R7 - Code held steady while pulses run
// R8 - Wait rise-in-code times step before change
// R9 - Disable hold code times step, input low
// R10 - Violated waits may cause spurious edges
// R11 - Pulse width at least total delay
// R12 - Never pulses under tenth of total delay
`timescale 1ns/1ps
`include "pdl_defines.vh"
module pdl_ctrl #(
    parameter CODE_W   = `PDL_CODE_W,
    parameter STEP_CYC = `PDL_STEP_CYC,
    parameter CNT_W    = `PDL_CNT_W
) (
    // Clock and reset
    input  wire              clk_i,
    input  wire              resetn_i,
    // User requests
    input  wire              pulse_req_i,
    input  wire              code_req_i,
    input  wire [CODE_W-1:0] code_i,
    input  wire              dis_req_i,
    input  wire              en_req_i,
    output reg               ready_o,
    output reg               enabled_o,
    // Device output, asynchronous to clk_i
    input  wire              dev_out_i,
    output reg               edge_seen_o,
    // Device pins
    output reg               dl_in_o,
    output reg [CODE_W-1:0]  delay_select_code_o,
    output reg               out_disable_n_a_o,
    output reg               out_disable_n_b_o
);
    // State codes
    localparam ST_IDLE  = 3'h0;
    localparam ST_HIGH  = 3'h1;
    localparam ST_LOW   = 3'h2;
    localparam ST_WAIT  = 3'h3;
    localparam ST_DIS   = 3'h4;

    reg [2:0]       state_r;      // Sequencer state
    reg [2:0]       state_nxt;    // Next state
    reg             sync1_r;      // First synchroniser stage
    reg             sync2_r;      // Second synchroniser stage
    reg             sync3_r;      // Previous synchronised value
    reg             load;         // Timer load strobe
    reg [CNT_W-1:0] load_val;     // Timer load value
    wire            busy;         // Timer running
    reg [CODE_W-1:0] pend_code_r; // Code waiting to be applied
    reg             pend_r;       // A code change is pending
    reg             rise_waited_r; // Upward code wait already served
    wire [CODE_W-1:0] code_rise;  // How far the pending code climbs
    // Fixed waits kept 32 bits wide, cut to the counter width where used
    localparam [31:0] SETUP_WAIT = `PDL_SETUP_CYC + 1;
    localparam [31:0] EN_WAIT    = `PDL_EN_SETUP_CYC + 1;

    // Only a rise in code needs extra settle time before it lands;
    // a fall can never stretch an edge that is still in flight
    assign code_rise = (pend_code_r > delay_select_code_o) ?
                       (pend_code_r - delay_select_code_o) : {CODE_W{1'b0}};

    // Total delay in cycles for a code: inherent plus code steps
    function [CNT_W-1:0] delay_cyc;
        input [CODE_W-1:0] code;
        reg   [31:0]       full;
        begin
            full      = `PDL_INHERENT_CYC + code * STEP_CYC; // R1 R3
            delay_cyc = full[CNT_W-1:0];
        end
    endfunction

    // Step wait for a code distance
    function [CNT_W-1:0] step_wait;
        input [CODE_W-1:0] code;
        reg   [31:0]       full;
        begin
            full      = code * STEP_CYC + 1; // R8 R9
            step_wait = full[CNT_W-1:0];
        end
    endfunction

    // Settle timer
    pdl_wait_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .load_i   (load),
        .count_i  (load_val),
        .busy_o   (busy)
    );

    // Two flops before any logic reads the device output
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= dev_out_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Sequencer: pulse, wait, code change and disable
    always @* begin
        state_nxt = state_r;
        load      = 1'b0;
        load_val  = {CNT_W{1'b0}};
        case (state_r)
            ST_IDLE: begin
                if (!busy && dis_req_i && enabled_o) begin
                    state_nxt = ST_DIS;
                    load      = 1'b1;
                    load_val  = step_wait(delay_select_code_o); // R9
                end else if (!busy && pend_r && !rise_waited_r) begin
                    // Old edges must clear the line before the code climbs
                    load     = 1'b1;
                    load_val = step_wait(code_rise); // R8
                end else if (!busy && pend_r) begin
                    load     = 1'b1;
                    load_val = SETUP_WAIT[CNT_W-1:0];
                end else if (!busy && pulse_req_i && enabled_o) begin
                    // Width is the full delay in cycles plus one cycle, safely above a tenth of it
                    state_nxt = ST_HIGH;
                    load      = 1'b1;
                    load_val  = delay_cyc(delay_select_code_o); // R11 R12
                end
            end
            ST_HIGH: begin
                if (!busy) begin
                    state_nxt = ST_LOW;
                    load      = 1'b1;
                    load_val  = delay_cyc(delay_select_code_o); // R11
                end
            end
            ST_LOW: begin
                // Falling edge must show on the device output before moving on
                if (!busy) begin
                    state_nxt = ST_WAIT;
                    load      = 1'b1;
                    load_val  = delay_cyc(delay_select_code_o) + {{(CNT_W-2){1'b0}}, 2'b10};
                end
            end
            ST_WAIT: begin
                if (!busy) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DIS: begin
                if (!busy && en_req_i) begin
                    state_nxt = ST_IDLE;
                    load      = 1'b1;
                    load_val  = EN_WAIT[CNT_W-1:0];
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Registered pin drive and status
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r             <= ST_IDLE;
            dl_in_o             <= 1'b0;
            delay_select_code_o <= {CODE_W{1'b0}};
            out_disable_n_a_o   <= 1'b1;
            out_disable_n_b_o   <= 1'b1;
            enabled_o           <= 1'b0;
            ready_o             <= 1'b0;
            edge_seen_o         <= 1'b0;
            pend_code_r         <= {CODE_W{1'b0}};
            pend_r              <= 1'b0;
            rise_waited_r       <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            edge_seen_o <= sync2_r & ~sync3_r;
            dl_in_o     <= (state_nxt == ST_HIGH); // R9 input low while disabled
            // Code captured here; the pins change only after the wait
            if (code_req_i && !pend_r) begin
                pend_code_r <= code_i;
                pend_r      <= 1'b1;
            end else if (state_r == ST_IDLE && !busy && pend_r && !(dis_req_i && enabled_o)) begin
                if (rise_waited_r) begin
                    // Rise wait served: the new code may land now
                    delay_select_code_o <= pend_code_r; // R7 R8 R10
                    pend_r              <= 1'b0;
                    rise_waited_r       <= 1'b0;
                end else begin
                    // First pass only starts the rise wait
                    rise_waited_r <= 1'b1; // R8
                end
            end
            // Both disable pins always from one decision
            if (state_nxt == ST_DIS) begin
                out_disable_n_a_o <= 1'b1; // R5 R6
                out_disable_n_b_o <= 1'b1; // R6
                enabled_o         <= 1'b0;
            end else if (state_r == ST_IDLE && !busy && !enabled_o && en_req_i) begin
                out_disable_n_a_o <= 1'b0; // R5 R6
                out_disable_n_b_o <= 1'b0; // R6
                enabled_o         <= 1'b1;
            end else if (state_r == ST_DIS && state_nxt == ST_IDLE) begin
                out_disable_n_a_o <= 1'b0; // R6
                out_disable_n_b_o <= 1'b0; // R6
                enabled_o         <= 1'b1;
            end
            // A code request being taken already makes the block busy
            ready_o <= (state_nxt == ST_IDLE) && !load && !busy && !pend_r && !code_req_i;
        end
    end

    // R4 true and inverted outputs are the device's; only the true one is watched
endmodule

// file: src/pdl_defines.vh
// Constants for the programmable delay line controller
`ifndef PDL_DEFINES_VH
`define PDL_DEFINES_VH

// Code width and highest code
`define PDL_CODE_W          6
`define PDL_CODE_MAX        6'h3F
// Delay step size in picoseconds (1 ns default variant)
`define PDL_STEP_PS         1000
// Clock period in picoseconds (100 MHz)
`define PDL_CLK_PS          10000
// Inherent delay in picoseconds
`define PDL_INHERENT_PS     9000
// Code to input setup time in picoseconds
`define PDL_CODE_SETUP_PS   5000
// Enable to input setup time in picoseconds
`define PDL_EN_SETUP_PS     2500
// Step count cycles, rounded up, at least one
`define PDL_STEP_CYC        ((`PDL_STEP_PS + `PDL_CLK_PS - 1) / `PDL_CLK_PS)
`define PDL_SETUP_CYC       ((`PDL_CODE_SETUP_PS + `PDL_CLK_PS - 1) / `PDL_CLK_PS)
`define PDL_EN_SETUP_CYC    ((`PDL_EN_SETUP_PS + `PDL_CLK_PS - 1) / `PDL_CLK_PS)
`define PDL_INHERENT_CYC    ((`PDL_INHERENT_PS + `PDL_CLK_PS - 1) / `PDL_CLK_PS)
// Counter width for waits
`define PDL_CNT_W           16

`endif

// file: src/pdl_wait_timer.v
// Down counter that times settle waits in clock cycles
`timescale 1ns/1ps
module pdl_wait_timer #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             resetn_i,
    // Load and status
    input  wire             load_i,
    input  wire [CNT_W-1:0] count_i,
    output reg              busy_o
);
    reg [CNT_W-1:0] cnt_r;  // Remaining cycles

    // Load wins over counting so a fresh wait is never shortened
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r  <= {CNT_W{1'b0}};
            busy_o <= 1'b0;
        end else if (load_i) begin
            cnt_r  <= count_i;
            busy_o <= (count_i != {CNT_W{1'b0}});
        end else if (cnt_r != {CNT_W{1'b0}}) begin
            cnt_r  <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
            busy_o <= (cnt_r != {{(CNT_W-1){1'b0}}, 1'b1});
        end else begin
            busy_o <= 1'b0;
        end
    end
endmodule

// file: verif/pdl_ctrl_bench.sv
// Self-checking bench for the delay line controller
`timescale 1ns/1ps
module pdl_ctrl_bench;
    reg        clk_i = 1'b0, resetn_i = 1'b0;
    reg        pulse_req_i = 1'b0, code_req_i = 1'b0, dis_req_i = 1'b0, en_req_i = 1'b0;
    reg  [5:0] code_i = 6'h00;
    wire       ready_o, enabled_o, dev_out, edge_seen_o, dl_in_o, dis_a, dis_b, dev_inv;
    wire [5:0] code_o;
    real       exp_q[$]; // Expected delays in ns
    real       t_in;
    integer    miscompares = 0, checks = 0;
    pdl_ctrl dut_u (.clk_i, .resetn_i, .pulse_req_i, .code_req_i, .code_i, .dis_req_i, .en_req_i,
        .ready_o, .enabled_o, .dev_out_i(dev_out), .edge_seen_o, .dl_in_o,
        .delay_select_code_o(code_o), .out_disable_n_a_o(dis_a), .out_disable_n_b_o(dis_b));
    pdl_dev_model dev_u (.in_i(dl_in_o), .code_i(code_o), .en_n_a_i(dis_a), .en_n_b_i(dis_b),
        .out_o(dev_out), .out_inv_o(dev_inv));
    initial forever #5 clk_i = ~clk_i;
    task wrap_up;
        begin
            $display("checks=%0d miscompares=%0d", checks, miscompares);
            if (miscompares == 0 && checks > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task fail(input [8*24-1:0] msg);
        begin
            miscompares++;
            $display("MISMATCH %0t %0s", $time, msg);
        end
    endtask
    task check_val(input logic [5:0] e, input logic [5:0] g);
        begin
            checks++;
            if (g !== e) fail("level or code");
        end
    endtask
    task check_delay(input real e, input real g);
        begin
            checks++;
            if (g < e - 0.01 || g > e + 0.01) fail("delay");
        end
    endtask
    // Bounded wait so a stuck controller cannot hang the run
    task wait_ready;
        integer n;
        begin
            n = 0;
            while (ready_o !== 1'b1 && n < 400) begin
                @(negedge clk_i);
                n++;
            end
            if (n >= 400) fail("ready timeout");
        end
    endtask
    // One-cycle request: 0 pulse, 1 code, 2 disable, 3 enable
    task strobe(input integer k);
        begin
            @(negedge clk_i);
            {pulse_req_i, code_req_i, dis_req_i, en_req_i} = 4'h8 >> k;
            @(negedge clk_i);
            {pulse_req_i, code_req_i, dis_req_i, en_req_i} = 4'h0;
        end
    endtask
    // Launch stamps the edge; every rising output edge takes the oldest note
    always @(posedge dl_in_o) t_in = $realtime;
    always @(posedge dev_out) begin
        if (exp_q.size() == 0) fail("unexpected edge");
        else check_delay(exp_q.pop_front(), $realtime - t_in);
    end
    initial begin
        #500000;
        fail("watchdog");
        wrap_up;
    end
    initial begin
        reg [5:0] c;
        integer   i;
        void'($urandom(32'hA077));
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) resetn_i = 1'b1;
        strobe(3);
        wait_ready;
        check_val(6'h01, {5'h00, enabled_o});
        // Boundary codes first, then random ones
        for (i = 0; i < 12; i++) begin
            c = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
            code_i = c;
            strobe(1);
            wait_ready;
            check_val(c, code_o);
            exp_q.push_back(9.0 + c);
            strobe(0);
            wait_ready;
        end
        // Disabled: pins high, pulse refused, outputs parked
        strobe(2);
        repeat (2) @(negedge clk_i);
        check_val(6'h03, {4'h0, dis_a, dis_b});
        check_val(6'h00, {5'h00, enabled_o});
        strobe(0);
        repeat (80) @(negedge clk_i);
        check_val(6'h01, {4'h0, dev_out, dev_inv});
        strobe(3);
        wait_ready;
        check_val(6'h00, {4'h0, dis_a, dis_b});
        exp_q.push_back(9.0 + c);
        strobe(0);
        wait_ready;
        repeat (20) @(negedge clk_i);
        check_val(6'h00, 6'(exp_q.size()));
        wrap_up;
    end
endmodule
bind pdl_ctrl pdl_ctrl_monitor #(.CODE_W(CODE_W)) mon_u (.clk_i, .resetn_i, .pulse_req_i, .code_req_i,
    .dis_req_i, .ready_o, .enabled_o, .dev_out_i, .edge_seen_o, .dl_in_o, .delay_select_code_o,
    .out_disable_n_a_o, .out_disable_n_b_o);

// file: verif/pdl_ctrl_monitor.sv
// Checker on the delay line controller pins
`timescale 1ns/1ps
module pdl_ctrl_monitor #(
    parameter CODE_W = 6
) (
    input wire              clk_i,
    input wire              resetn_i,
    input wire              pulse_req_i,
    input wire              code_req_i,
    input wire              dis_req_i,
    input wire              ready_o,
    input wire              enabled_o,
    input wire              dev_out_i,
    input wire              edge_seen_o,
    input wire              dl_in_o,
    input wire [CODE_W-1:0] delay_select_code_o,
    input wire              out_disable_n_a_o,
    input wire              out_disable_n_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    pins_equal_a: assert property (out_disable_n_a_o == out_disable_n_b_o)
        else $error("disable pins differ");
    code_steady_a: assert property (dl_in_o |-> $stable(delay_select_code_o))
        else $error("code moved during pulse");
    code_after_a: assert property ($fell(dl_in_o) |=> $stable(delay_select_code_o) [*8])
        else $error("code changed too soon");
    dis_quiet_a: assert property (out_disable_n_a_o |-> !dl_in_o)
        else $error("input active while disabled");
    width_min_a: assert property ($rose(dl_in_o) |-> dl_in_o [*2])
        else $error("pulse too narrow");
    busy_pulse_a: assert property ($rose(dl_in_o) |-> !ready_o)
        else $error("ready during pulse");
    pulse_start_a: assert property (pulse_req_i && ready_o && enabled_o && !dis_req_i && !code_req_i |=> dl_in_o)
        else $error("pulse not launched");
    en_pins_a: assert property (enabled_o |-> !out_disable_n_a_o)
        else $error("enabled while pins disable");
    edge_seen_a: assert property ($rose(dev_out_i) |-> ##[1:5] edge_seen_o)
        else $error("output edge missed");
    pulse_c: cover property ($rose(dl_in_o));
    dis_c: cover property ($rose(out_disable_n_a_o));
    code_c: cover property ($changed(delay_select_code_o));
endmodule

// file: verif/pdl_dev_model.sv
// Behavioural model of the programmable delay line
`timescale 1ns/1ps
module pdl_dev_model #(
    parameter real STEP_NS = 1.0, // Fixed per variant, 0.5 to 10 ns
    parameter real INH_NS  = 9.0  // Inherent delay
) (
    input  wire       in_i,
    input  wire [5:0] code_i,
    input  wire       en_n_a_i,
    input  wire       en_n_b_i,
    output wire       out_o,
    output wire       out_inv_o
);
    reg       dly_r    = 1'b0;  // Delayed copy of the input
    reg       spur_r   = 1'b0;  // Glitch left by a premature code change
    reg       spur_hit = 1'b0;  // Latest code change came too soon
    reg [5:0] code_old = 6'h00; // Code before the latest change
    real      t_edge   = 0.0;   // Time the latest delayed edge appeared
    // Transport delay grows with the code, so it never falls as the code rises
    always @(in_i) dly_r <= #(INH_NS + STEP_NS * code_i) in_i;
    always @(dly_r) t_edge = $realtime;
    // A rise in code too soon after the last edge leaves a short glitch
    always @(code_i) begin
        spur_hit = (code_i > code_old) && ($realtime < t_edge + STEP_NS * (code_i - code_old));
        code_old = code_i;
        if (spur_hit) begin
            spur_r = 1'b1;
            #1 spur_r = 1'b0;
        end
    end
    // Either pin high forces both outputs to their parked levels
    assign out_o     = (en_n_a_i | en_n_b_i) ? 1'b0 : (dly_r | spur_r);
    assign out_inv_o = (en_n_a_i | en_n_b_i) ? 1'b1 : ~(dly_r | spur_r);
endmodule
